//--- rtl/sst_consts.svh
/*
 * Constants of the STOP-exit and limp-home clock recovery block: register
 * offsets, field positions, reset values and delay counts.
 * Assumes a 20 MHz pclk and an APB master with 32-bit data.
 */
// How it works
// - After reset with PLL supply present, the block enters limp-home mode.
// - The exit counter ticks through the slow-mode divider outside limp-home, on the VCO in limp-home.
// - STOP with monitor on and limp-home off gives clock monitor reset.
// - Delayed limp-home exit waits 4096 VCO counts before checking monitor.
// - Delayed pseudo-STOP exit leaves in limp-home with oscillator running.
// - Delayed pseudo-STOP exit without limp-home resumes after 4096 counts.
// - Multiplier always readable; writes ignored while the control PLL bus select bit is set.
// - Bus multiplier equals loop multiplier plus one when PLL on.
// - System clock multiplier is twice the bus multiplier.
// - Limp-home forces PLL bus select high, module select low, VCO counter.
// - Clock found at a 4096 check ends limp-home and sets flag.
// - Zero-delay exit without limp-home or monitor resumes after 16 counts.
// - STOP enters pseudo-STOP when pseudo-STOP enable is set.
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH

// Register byte offsets
`define SST_OFF_MULT      8'h38
`define SST_OFF_CTRL      8'h3C
`define SST_OFF_SLOW      8'h40
`define SST_OFF_STATUS    8'h44
`define SST_OFF_IRQ_STAT  8'h48
`define SST_OFF_IRQ_MASK  8'h4C

// Reset values
`define SST_MULT_RESET    8'h00
`define SST_CTRL_RESET    8'h20
`define SST_SLOW_RESET    6'h00
`define SST_IRQ_RESET     2'h0

// Interrupt status bit positions
`define SST_IRQ_LIMP      0
`define SST_IRQ_EXIT      1

// Exit delay counts and supply settle count
`define SST_LONG_COUNT    13'h1000
`define SST_SHORT_COUNT   13'h0010
`define SST_SYNC_SETTLE   13'h0004

`endif

//--- rtl/sst_pkg.sv
/*
 * Types of the STOP-exit and limp-home clock recovery block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sst_pkg;

    // Recovery sequencer states
    typedef enum logic [2:0] {
        SST_INIT       = 3'b000,
        SST_RUN        = 3'b001,
        SST_STOP       = 3'b010,
        SST_XTAL_WAIT  = 3'b011,
        SST_LIMP_DELAY = 3'b100,
        SST_LIMP       = 3'b101
    } sst_state_t;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic module_clock_select;
        logic bus_clock_pll_select;
        logic stop_exit_delay_select;
        logic forced_clock_monitor_enable;
        logic clock_monitor_enable;
        logic pseudo_stop_enable;
        logic reserved;
        logic no_limp_home_select;
    } sst_ctrl_t;

endpackage

//--- rtl/sst_sync.sv
/*
 * Three-stage synchroniser for one level from outside the pclk domain.
 * The output follows only when the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none

module sst_sync
    import sst_pkg::*;
(
    input  wire logic pclk,      // Block clock
    input  wire logic presetn,   // Async reset, active low
    input  wire logic async_in,  // Level from another domain
    output logic      sync_out   // Filtered level
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_sync_out;

    // Accept a change only once the last two stages agree
    always_comb
    begin
        next_sync_out = sync_out;
        if (stage2 == stage3)
            next_sync_out = stage3;
    end

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1   <= 1'b0;
            stage2   <= 1'b0;
            stage3   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            stage1   <= async_in;
            stage2   <= stage1;
            stage3   <= stage2;
            sync_out <= next_sync_out;
        end
    end
endmodule

`default_nettype wire

//--- rtl/sst_divider.sv
/*
 * Slow-mode divider producing the crystal-side counter tick.
 * pclk stands for the crystal clock; one tick per counter clock period:
 * every 2 cycles when the setting is zero, else every 4 times the setting.
 */
`timescale 1ns/1ps
`default_nettype none

module sst_divider
    import sst_pkg::*;
#(
    parameter int SLOW_W = 6     // Width of the slow divider setting
)
(
    input  wire logic              pclk,     // Block clock
    input  wire logic              presetn,  // Async reset, active low
    input  wire logic [SLOW_W-1:0] slow,     // Slow divider setting
    output logic                   tick      // One-cycle counter tick
);
    logic [SLOW_W+1:0] count;
    logic [SLOW_W+1:0] next_count;
    logic [SLOW_W+1:0] period;
    logic              next_tick;

    // Divide by two for the counter clock on top of the slow divide
    always_comb
    begin
        period = (slow == '0) ? (SLOW_W+2)'(2) : {slow, 2'b00};
        next_tick  = 1'b0;
        next_count = count + 1'b1;
        if (next_count >= period)
        begin
            next_count = '0;
            next_tick  = 1'b1;
        end
    end

    // A setting change acts within one period, no restart needed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule

`default_nettype wire

//--- rtl/sst_top.sv
/*
 * STOP and pseudo-STOP exit sequencer with limp-home recovery, loop
 * multiplier register and APB register file.
 * Assumes the clock monitor result, PLL supply level and VCO clock arrive
 * as asynchronous pins; the VCO is much slower than pclk.
 */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sst_consts.svh"

module sst_top
    import sst_pkg::*;
#(
    parameter int CNT_W  = 13,   // Exit counter width
    parameter int SLOW_W = 6     // Slow divider width
)
(
    input  wire logic        pclk,                     // Block clock, 20 MHz
    input  wire logic        presetn,                  // Async reset, active low
    input  wire logic        psel,                     // APB select
    input  wire logic        penable,                  // APB access phase
    input  wire logic        pwrite,                   // APB write
    input  wire logic [7:0]  paddr,                    // APB byte address
    input  wire logic [31:0] pwdata,                   // APB write data
    output logic      [31:0] prdata,                   // APB read data
    output logic             pready,                   // APB ready
    output logic             pslverr,                  // APB error, unmapped
    input  wire logic        stop_request,             // STOP executed, pulse
    input  wire logic        wake_request,             // Wake event, pulse
    input  wire logic        pll_supply_rail,          // PLL supply present
    input  wire logic        ext_clock_present,        // Clock monitor result
    input  wire logic        vco_clock,                // VCO clock pin
    output logic             cpu_clock_run,            // CPU clocked
    output logic             oscillator_run,           // Crystal oscillator on
    output logic             clock_monitor_reset,      // Monitor reset, pulse
    output logic             bus_clock_pll_select_out, // Effective PLL bus select
    output logic             module_clock_select_out,  // Effective module select
    output logic             limp_home_status,         // In limp-home mode
    output logic [8:0]       bus_multiplier,           // Bus over reference
    output logic [9:0]       system_multiplier,        // System over reference
    output logic             irq                       // Level interrupt
);
    sst_state_t        state;
    sst_state_t        next_state;
    sst_ctrl_t         ctrl;
    sst_ctrl_t         next_ctrl;
    sst_ctrl_t         ctrl_view;
    logic [7:0]        loop_multiplier;
    logic [7:0]        next_loop_multiplier;
    logic [SLOW_W-1:0] slow;
    logic [SLOW_W-1:0] next_slow;
    logic [1:0]        irq_status;
    logic [1:0]        next_irq_status;
    logic [1:0]        irq_mask;
    logic [1:0]        next_irq_mask;
    logic [31:0]       next_prdata;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  next_count;
    logic [CNT_W-1:0]  wait_limit;
    logic [CNT_W-1:0]  next_wait_limit;
    logic              next_limp_home_status;
    logic              next_clock_monitor_reset;
    logic              pseudo;
    logic              next_pseudo;
    logic [8:0]        next_bus_multiplier;
    logic [9:0]        next_system_multiplier;
    logic              supply_ok;
    logic              clock_ok;
    logic              vco_level;
    logic              vco_prev;
    logic              vco_tick;
    logic              xtal_tick;
    logic              count_tick;
    logic              in_limp;
    logic              monitor_on;
    logic              wr;
    logic              rd;
    logic              mapped;
    logic              limp_event;
    logic              exit_event;

    // Asynchronous pins pass three stages each
    sst_sync u_sync_supply (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pll_supply_rail),
        .sync_out (supply_ok)
    );
    sst_sync u_sync_clock (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ext_clock_present),
        .sync_out (clock_ok)
    );
    sst_sync u_sync_vco (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (vco_clock),
        .sync_out (vco_level)
    );

    // Crystal-side counter clock through the slow divider
    sst_divider #(
        .SLOW_W (SLOW_W)
    ) u_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .slow    (slow),
        .tick    (xtal_tick)
    );

    // Counter source: VCO in limp-home, slow-divided crystal otherwise
    assign in_limp    = (state == SST_LIMP_DELAY) || (state == SST_LIMP);
    assign vco_tick   = vco_level && !vco_prev;
    assign count_tick = in_limp ? vco_tick : xtal_tick;
    assign monitor_on = ctrl.clock_monitor_enable || ctrl.forced_clock_monitor_enable;

    // Control view: low PLL supply forces no-limp-home; other bits pass unchanged
    always_comb
    begin
        ctrl_view = ctrl;
        if (!supply_ok)
            ctrl_view.no_limp_home_select = 1'b1;
    end

    // Recovery sequencer
    always_comb
    begin
        next_state               = state;
        next_count               = count;
        next_wait_limit          = wait_limit;
        next_pseudo              = pseudo;
        next_limp_home_status    = limp_home_status;
        next_clock_monitor_reset = 1'b0;
        limp_event               = 1'b0;
        exit_event               = 1'b0;
        unique case (state)
            SST_INIT:
            begin
                // Supply sync needs four edges; decide only once it settled
                if (supply_ok)
                begin
                    next_state            = SST_LIMP;
                    next_limp_home_status = 1'b1;
                    next_count            = '0;
                end
                else if (count == `SST_SYNC_SETTLE)
                    next_state = SST_RUN;
                else
                    next_count = count + 1'b1;
            end
            SST_RUN:
            begin
                if (stop_request)
                begin
                    if (ctrl_view.no_limp_home_select && monitor_on)
                        next_clock_monitor_reset = 1'b1;
                    else
                    begin
                        next_state  = SST_STOP;
                        next_pseudo = ctrl.pseudo_stop_enable;
                    end
                end
            end
            SST_STOP:
            begin
                if (wake_request)
                begin
                    next_count = '0;
                    if (ctrl_view.no_limp_home_select)
                    begin
                        next_state      = SST_XTAL_WAIT;
                        next_wait_limit = ctrl.stop_exit_delay_select
                                        ? `SST_LONG_COUNT
                                        : `SST_SHORT_COUNT;
                    end
                    else if (ctrl.stop_exit_delay_select)
                        next_state = SST_LIMP_DELAY;
                    else
                    begin
                        // Fast recovery runs the CPU on the VCO at once
                        next_state            = SST_LIMP;
                        next_limp_home_status = 1'b1;
                        limp_event            = 1'b1;
                    end
                end
            end
            SST_XTAL_WAIT:
            begin
                if (count_tick)
                    next_count = count + 1'b1;
                if (count_tick && (count + 1'b1 == wait_limit))
                begin
                    next_state  = SST_RUN;
                    next_pseudo = 1'b0;
                    exit_event  = 1'b1;
                end
            end
            SST_LIMP_DELAY, SST_LIMP:
            begin
                if (count_tick)
                    next_count = count + 1'b1;
                // Monitor is checked each time the count reaches 4096
                if (count_tick && (count + 1'b1 == `SST_LONG_COUNT))
                begin
                    next_count = '0;
                    if (clock_ok)
                    begin
                        next_state            = SST_RUN;
                        next_pseudo           = 1'b0;
                        next_limp_home_status = 1'b0;
                        exit_event            = 1'b1;
                        limp_event            = limp_home_status;
                    end
                    else if (state == SST_LIMP_DELAY)
                    begin
                        next_state            = SST_LIMP;
                        next_limp_home_status = 1'b1;
                        limp_event            = 1'b1;
                        exit_event            = 1'b1;
                    end
                end
            end
            default:
                next_state = SST_INIT;
        endcase
    end

    // Effective clock selects and multipliers
    always_comb
    begin
        bus_clock_pll_select_out = in_limp ? 1'b1 : ctrl.bus_clock_pll_select;
        module_clock_select_out  = in_limp ? 1'b0 : ctrl.module_clock_select;
        cpu_clock_run  = (state == SST_RUN) || (state == SST_LIMP);
        // Pseudo-STOP keeps the crystal alive while in STOP
        oscillator_run = (state != SST_STOP) || pseudo;
        next_bus_multiplier    = {1'b0, loop_multiplier} + 9'h001;
        next_system_multiplier = {next_bus_multiplier, 1'b0};
    end

    // APB decode; zero-wait, read data captured in setup cycle
    assign pready = 1'b1;
    assign wr     = psel && penable && pwrite;
    assign rd     = psel && !penable && !pwrite;
    always_comb
    begin
        mapped = (paddr == `SST_OFF_MULT) || (paddr == `SST_OFF_CTRL)
              || (paddr == `SST_OFF_SLOW) || (paddr == `SST_OFF_STATUS)
              || (paddr == `SST_OFF_IRQ_STAT) || (paddr == `SST_OFF_IRQ_MASK);
        pslverr = psel && penable && !mapped;
    end

    // Register writes and sticky flags
    always_comb
    begin
        next_loop_multiplier = loop_multiplier;
        next_ctrl            = ctrl;
        next_slow            = slow;
        next_irq_mask        = irq_mask;
        next_irq_status      = irq_status;
        if (wr)
        begin
            unique case (paddr)
                `SST_OFF_MULT:
                    // Retuning the loop under a live PLL bus clock is unsafe
                    if (!ctrl.bus_clock_pll_select)
                        next_loop_multiplier = pwdata[7:0];
                `SST_OFF_CTRL:
                    next_ctrl = sst_ctrl_t'(pwdata[7:0]);
                `SST_OFF_SLOW:
                    next_slow = pwdata[SLOW_W-1:0];
                `SST_OFF_IRQ_STAT:
                    next_irq_status = irq_status & ~pwdata[1:0];
                `SST_OFF_IRQ_MASK:
                    next_irq_mask = pwdata[1:0];
                default:
                    next_irq_mask = irq_mask;
            endcase
        end
        next_ctrl.reserved = 1'b0;
        // Set wins over a same-cycle clear
        if (limp_event)
            next_irq_status[`SST_IRQ_LIMP] = 1'b1;
        if (exit_event)
            next_irq_status[`SST_IRQ_EXIT] = 1'b1;
    end

    // Read mux
    always_comb
    begin
        next_prdata = prdata;
        if (rd)
        begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                `SST_OFF_MULT:     next_prdata[7:0] = loop_multiplier;
                `SST_OFF_CTRL:     next_prdata[7:0] = ctrl_view;
                `SST_OFF_SLOW:     next_prdata[SLOW_W-1:0] = slow;
                `SST_OFF_STATUS:   next_prdata[5:0] = {oscillator_run, cpu_clock_run,
                                                       state, limp_home_status};
                `SST_OFF_IRQ_STAT: next_prdata[1:0] = irq_status;
                `SST_OFF_IRQ_MASK: next_prdata[1:0] = irq_mask;
                default:           next_prdata = 32'h0000_0000;
            endcase
        end
    end

    assign irq = |(irq_status & irq_mask);

    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state               <= SST_INIT;
            count               <= '0;
            wait_limit          <= `SST_LONG_COUNT;
            pseudo              <= 1'b0;
            limp_home_status    <= 1'b0;
            clock_monitor_reset <= 1'b0;
            vco_prev            <= 1'b0;
            ctrl                <= sst_ctrl_t'(`SST_CTRL_RESET);
            loop_multiplier     <= `SST_MULT_RESET;
            slow                <= `SST_SLOW_RESET;
            irq_status          <= `SST_IRQ_RESET;
            irq_mask            <= `SST_IRQ_RESET;
            prdata              <= 32'h0000_0000;
            bus_multiplier      <= 9'h001;
            system_multiplier   <= 10'h002;
        end
        else
        begin
            state               <= next_state;
            count               <= next_count;
            wait_limit          <= next_wait_limit;
            pseudo              <= next_pseudo;
            limp_home_status    <= next_limp_home_status;
            clock_monitor_reset <= next_clock_monitor_reset;
            vco_prev            <= vco_level;
            ctrl                <= next_ctrl;
            loop_multiplier     <= next_loop_multiplier;
            slow                <= next_slow;
            irq_status          <= next_irq_status;
            irq_mask            <= next_irq_mask;
            prdata              <= next_prdata;
            bus_multiplier      <= next_bus_multiplier;
            system_multiplier   <= next_system_multiplier;
        end
    end
endmodule

`default_nettype wire

//--- verif/sst_props.sv
/*
 * Checker of sst_top port relations: multiplier, selects, STOP entry.
 * Assumes one pclk domain and presetn active low; bound to sst_top.
 */
`timescale 1ns/1ps
`default_nettype none

module sst_props (
    input wire logic       pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic       stop_request, cpu_clock_run, oscillator_run,
    input wire logic       clock_monitor_reset, limp_home_status,
    input wire logic       bus_clock_pll_select_out, module_clock_select_out,
    input wire logic [8:0] bus_multiplier,
    input wire logic [9:0] system_multiplier
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Multiplier write in normal run; limp states force the select output
    wire logic wr_mult = psel && penable && pwrite && paddr == 8'h38
                       && cpu_clock_run && !limp_home_status;

    chk_mult_plus: assert property (
        wr_mult && !bus_clock_pll_select_out
        |-> ##2 bus_multiplier == {1'b0, $past(pwdata[7:0], 2)} + 9'h001)
        else $error("multiplier not value plus one");
    chk_mult_lock: assert property (
        wr_mult && bus_clock_pll_select_out
        |-> ##2 bus_multiplier == $past(bus_multiplier, 2))
        else $error("multiplier written under PLL");
    chk_sys_twice: assert property (
        system_multiplier == {bus_multiplier, 1'b0})
        else $error("system multiplier not twice bus");
    chk_limp_force: assert property (
        limp_home_status |-> bus_clock_pll_select_out && !module_clock_select_out)
        else $error("selects not forced in limp-home");
    chk_limp_exit: assert property (
        $fell(limp_home_status) |-> cpu_clock_run && oscillator_run)
        else $error("limp-home left without running clock");
    chk_mon_cause: assert property (
        clock_monitor_reset |-> $past(stop_request) && cpu_clock_run)
        else $error("monitor reset without STOP");
    chk_mon_pulse: assert property (
        clock_monitor_reset |=> !clock_monitor_reset)
        else $error("monitor reset longer than a cycle");
    chk_stop_take: assert property (
        stop_request && cpu_clock_run && !limp_home_status
        |=> clock_monitor_reset || !cpu_clock_run)
        else $error("STOP request not taken");
    chk_osc_stop: assert property (
        $fell(oscillator_run) |-> !cpu_clock_run)
        else $error("oscillator stopped while running");

    cover property (limp_home_status);
    cover property (clock_monitor_reset);
    cover property ($fell(limp_home_status));
endmodule

bind sst_top sst_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .stop_request, .cpu_clock_run, .oscillator_run,
    .clock_monitor_reset, .limp_home_status, .bus_clock_pll_select_out,
    .module_clock_select_out, .bus_multiplier, .system_multiplier);

`default_nettype wire

//--- verif/sst_osc_model.sv
/*
 * Far side: clock source as the monitor sees it, and the slowest VCO.
 * Assumes pclk stands for the crystal; the bench decides clock health.
 */
`timescale 1ns/1ps
`default_nettype none

module sst_osc_model (
    input  wire logic pclk,              // Reference clock
    input  wire logic osc_ok,            // Bench: source healthy
    output logic      vco_clock,         // VCO, six pclk per period
    output logic      ext_clock_present  // Clock monitor result
);
    logic [1:0] ph = 2'h0;

    // Slow VCO keeps well under pclk/4 for the pin synchroniser
    initial vco_clock = 1'b0;
    always @(posedge pclk)
    begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        if (ph == 2'h2)
            vco_clock <= ~vco_clock;
    end

    // Square-wave source: settles inside any count, no start-up
    assign ext_clock_present = osc_ok;
endmodule

`default_nettype wire

//--- verif/tb_stop_exit_clock_recovery.sv
/*
 * Self-checking bench for sst_top.
 * Assumes sst_osc_model as the clock source and the checker bound in.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_stop_exit_clock_recovery;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic stop_request = 0, wake_request = 0, pll_supply_rail = 1, osc_ok = 1;
    logic [7:0] paddr = 0, m;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, cpu_clock_run, oscillator_run, clock_monitor_reset;
    logic bus_clock_pll_select_out, module_clock_select_out, limp_home_status;
    logic irq, vco_clock, ext_clock_present, mon_seen = 0;
    logic [8:0] bus_multiplier;
    logic [9:0] system_multiplier;
    int n_fail = 0, n_tests = 0, n, e;

    always #25 pclk = ~pclk;

    sst_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .stop_request, .wake_request,
        .pll_supply_rail, .ext_clock_present, .vco_clock, .cpu_clock_run,
        .oscillator_run, .clock_monitor_reset, .bus_clock_pll_select_out,
        .module_clock_select_out, .limp_home_status, .bus_multiplier,
        .system_multiplier, .irq);
    sst_osc_model osc (.pclk, .osc_ok, .vco_clock, .ext_clock_present);

    // Catch the one-cycle monitor pulse
    always @(posedge pclk)
        if (clock_monitor_reset)
            mon_seen <= 1'b1;

    task complete_run;
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Exit delay in pclk via the slow divider
    function int exit_cycles(input int ticks, input int slow);
        return ticks * ((slow == 0) ? 2 : 4 * slow);
    endfunction

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i <= 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i > 16)
        begin
            n_fail++;
            complete_run;
        end
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    endtask

    task pulse(input bit wk);
        @(posedge pclk);
        if (wk) wake_request <= 1; else stop_request <= 1;
        @(posedge pclk);
        wake_request <= 0; stop_request <= 0;
    endtask

    // Bounded wait for cpu clock (sel 0) or limp status (sel 1) to reach v
    task wait_for(input bit sel, input logic v, input int lim);
        n = 0;
        while ((sel ? limp_home_status : cpu_clock_run) !== v)
        begin
            @(posedge pclk);
            n++;
            if (n > lim)
            begin
                n_fail++;
                complete_run;
            end
        end
    endtask

    initial
    begin
        void'($urandom(82474));
        repeat (10) @(posedge pclk);
        presetn <= 1; // held well past start-up
        repeat (6) @(posedge pclk);
        apb(0, 8'h38, 0); chk("mult reset", rd, 0);
        apb(0, 8'h3C, 0); chk("ctrl reset", rd, 32'h20);
        chk("reset limp", limp_home_status, 1);
        wait_for(1, 0, 30000);
        apb(0, 8'h10, 0); chk("unmapped err", err, 1);
        for (int k = 0; k < 6; k++)
        begin
            m = (k == 0) ? 8'hFF : 8'($urandom_range(254));
            apb(1, 8'h38, {24'h0, m});
            apb(0, 8'h38, 0); chk("mult read", rd, m);
            chk("bus mult", bus_multiplier, m + 32'h1);
            chk("sys mult", system_multiplier, 2 * (m + 32'h1));
        end
        apb(1, 8'h3C, 32'h60); apb(1, 8'h38, 32'h12);
        apb(0, 8'h38, 0); chk("mult locked", rd, m);
        apb(1, 8'h3C, 32'h29); pulse(0); repeat (2) @(negedge pclk);
        chk("monitor reset", mon_seen, 1);
        chk("still running", cpu_clock_run, 1);
        apb(1, 8'h3C, 32'h05); pulse(0); @(negedge pclk);
        chk("pseudo osc", oscillator_run, 1);
        pulse(1); wait_for(0, 1, 200);
        chk("fast exit", n >= 28 && n <= 36, 1);
        apb(1, 8'h3C, 32'h01); pulse(0); @(negedge pclk);
        chk("stop osc", oscillator_run, 0);
        pulse(1); wait_for(0, 1, 200);
        apb(1, 8'h40, 1); apb(1, 8'h3C, 32'h25); pulse(0); pulse(1);
        wait_for(0, 1, 20000); e = exit_cycles(4096, 1);
        chk("slow exit", n >= e - 8 && n <= e + 8, 1);
        apb(1, 8'h40, 0); apb(1, 8'h4C, 3); apb(1, 8'h48, 3);
        osc_ok <= 0;
        apb(1, 8'h3C, 32'hA4); pulse(0); pulse(1);
        wait_for(0, 1, 30000); e = 4096 * 6;
        chk("vco delay", n >= e - 40 && n <= e + 40, 1);
        @(negedge pclk);
        chk("limp entry", limp_home_status, 1);
        chk("pll sel", bus_clock_pll_select_out, 1);
        chk("mod sel", module_clock_select_out, 0);
        chk("irq set", irq, 1);
        apb(1, 8'h48, 3); @(negedge pclk); chk("irq clear", irq, 0);
        apb(1, 8'h4C, 0); osc_ok <= 1;
        wait_for(1, 0, 30000); @(negedge pclk);
        chk("limp exit run", cpu_clock_run, 1);
        chk("irq masked", irq, 0);
        apb(1, 8'h4C, 3); @(negedge pclk); chk("irq exit", irq, 1);
        complete_run;
    end
endmodule

`default_nettype wire
